// >>> src/irq_pkg.sv
package irq_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_PSC = 8'h00;
    localparam logic [7:0] OFS_TB0 = 8'h04;
    localparam logic [7:0] OFS_TB1 = 8'h08;
    localparam logic [7:0] OFS_FLAG = 8'h0C;
    localparam logic [7:0] OFS_EN = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int TB_RUN_BIT = 7;
    localparam int TB_PER_LSB = 0;
    localparam int CONV_BIT = 12;
    localparam int ASYNC_BIT = 13;
    localparam int MASTER_BIT = 15;
    localparam int VEC_LSB = 4;
    localparam logic [1:0] PSC_RESET = 2'h0;
    localparam logic [7:0] TB_RESET = 8'h00;
    localparam logic [1:0] PSC_SYS = 2'h0;
    localparam logic [1:0] PSC_DIV4 = 2'h1;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam int TB_MIN_LOG2 = 8;

    // ****************************************
    // Request sources, in priority order
    // ****************************************
    localparam int NSRC = 12;
    localparam int SRC_CMP0 = 0;
    localparam int SRC_SIM = 2;
    localparam int SRC_SPORT = 3;
    localparam int SRC_TB0 = 4;
    localparam int SRC_GRP0 = 6;
    localparam int NGRP = 6;
    localparam int GRP_CONV = 0;
    localparam int GRP_ASYNC = 1;

    typedef struct packed {
        logic rx_tx_done;
        logic addr_match;
        logic bus_timeout;
    } sim_events_t;

    typedef struct packed {
        logic byte_done;
        logic incomplete;
    } sport_events_t;

    typedef struct packed {
        logic tx_empty;
        logic tx_idle;
        logic rx_avail;
        logic rx_overrun;
        logic addr_detect;
        logic rx_wake;
    } async_events_t;
endpackage

// >>> src/timebase_counter.sv
`timescale 1ns/1ns
`default_nettype none
module timebase_counter
    import irq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic run,
    input wire logic [2:0] period,
    output logic ovf
);
    logic [14:0] cnt_r;
    logic [14:0] limit;
    logic wrap;

    // ****************************************
    // Divider chain
    // ****************************************
    assign limit = 15'((32'h1 << (TB_MIN_LOG2 + 32'(period))) - 32'h1);
    assign wrap = run && tick && (cnt_r >= limit);

    // Stopped chain restarts from zero so the first period is whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 15'h0000;
            ovf <= 1'b0;
        end else begin
            ovf <= wrap;
            if (!run) begin
                cnt_r <= 15'h0000;
            end else if (tick) begin
                cnt_r <= wrap ? 15'h0000 : cnt_r + 15'h0001;
            end
        end
    end

    a_ovf_period: assert property (@(posedge pclk) disable iff (!presetn)
        ovf |-> $past(cnt_r) == $past(limit))
        else $error("time base overflow at wrong count");
    a_stop_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !run |=> !ovf)
        else $error("stopped time base overflowed");
endmodule
`default_nettype wire

// >>> src/periph_irq_timebase.sv
`timescale 1ns/1ns
`default_nettype none
module periph_irq_timebase
    import irq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] cmp_out,
    input wire sim_events_t sim_ev,
    input wire sport_events_t sport_ev,
    input wire logic conv_done,
    input wire async_events_t async_ev,
    input wire logic [NGRP-1:0] group_ext_set,
    input wire logic sub_clk_pin,
    input wire logic stack_full,
    input wire logic return_from_irq,
    output logic irq_take,
    output logic [3:0] irq_vector,
    output logic wake
);
    // ****************************************
    // State
    // ****************************************
    logic [1:0] psc_r;
    logic [7:0] tb_ctl_r [2];
    logic [NSRC-1:0] src_flag_r;
    logic [NSRC-1:0] src_en_r;
    logic conv_flag_r;
    logic async_flag_r;
    logic conv_en_r;
    logic async_en_r;
    logic master_r;
    logic [1:0] cmp_prev_r;
    logic [1:0] div_r;
    logic sub_s1_r;
    logic sub_s2_r;
    logic sub_s3_r;
    logic [NSRC-1:0] flag_prev_r;
    logic [1:0] tb_ovf;

    // ****************************************
    // Bus decode
    // ****************************************
    wire setup = psel && !penable;
    wire wr = psel && penable && pwrite && pready;
    wire hit_psc = paddr == OFS_PSC;
    wire hit_tb0 = paddr == OFS_TB0;
    wire hit_tb1 = paddr == OFS_TB1;
    wire hit_flag = paddr == OFS_FLAG;
    wire hit_en = paddr == OFS_EN;
    wire hit_stat = paddr == OFS_STAT;
    wire mapped = hit_psc || hit_tb0 || hit_tb1 || hit_flag || hit_en || hit_stat;
    wire wr_flag = wr && hit_flag;
    wire wr_en = wr && hit_en;

    // ****************************************
    // Prescaler and time bases
    // ****************************************
    wire tick4 = div_r == DIV4_LAST;
    wire sub_tick = sub_s2_r && !sub_s3_r;
    wire psc_tick = psc_r[1] ? sub_tick : ((psc_r == PSC_DIV4) ? tick4 : 1'b1);

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_tb
            timebase_counter u_tb (
                .pclk(pclk),
                .presetn(presetn),
                .tick(psc_tick),
                .run(tb_ctl_r[g][TB_RUN_BIT]),
                .period(tb_ctl_r[g][TB_PER_LSB +: 3]),
                .ovf(tb_ovf[g])
            );
        end
    endgenerate

    // ****************************************
    // Request set terms
    // ****************************************
    wire [1:0] cmp_tog = cmp_out ^ cmp_prev_r;
    wire sim_set = sim_ev.rx_tx_done || sim_ev.addr_match || sim_ev.bus_timeout;
    wire sport_set = sport_ev.byte_done || sport_ev.incomplete;
    wire async_set = |async_ev;
    // Member must be enabled to feed its group; group_ext_set still sets the group flag on its own
    wire conv_rise = conv_done && !conv_flag_r && conv_en_r;
    wire async_rise = async_set && !async_flag_r && async_en_r;

    logic [NGRP-1:0] grp_set;
    always_comb begin
        grp_set = group_ext_set;
        grp_set[GRP_CONV] = group_ext_set[GRP_CONV] || conv_rise;
        grp_set[GRP_ASYNC] = group_ext_set[GRP_ASYNC] || async_rise;
    end

    wire [NSRC-1:0] src_set = {grp_set, tb_ovf, sport_set, sim_set, cmp_tog};

    // ****************************************
    // Vector arbitration
    // ****************************************
    wire [NSRC-1:0] pend = src_flag_r & src_en_r;
    wire can_take = master_r && !stack_full && (|pend) && !irq_take;

    logic [3:0] win;
    always_comb begin
        win = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                win = 4'(i);
            end
        end
    end

    wire [NSRC-1:0] take_clr = can_take ? (NSRC'(1) << win) : '0;
    wire [NSRC-1:0] sw_clr = wr_flag ? pwdata[NSRC-1:0] : '0;
    // Set wins over both clears, so no event is lost
    wire [NSRC-1:0] src_flag_nxt = (src_flag_r & ~take_clr & ~sw_clr) | src_set;
    wire conv_flag_nxt = (conv_flag_r && !(wr_flag && pwdata[CONV_BIT])) || conv_done;
    wire async_flag_nxt = (async_flag_r && !(wr_flag && pwdata[ASYNC_BIT])) || async_set;
    wire master_nxt = can_take ? 1'b0 :
        (return_from_irq || (wr_en ? pwdata[MASTER_BIT] : master_r));

    // ****************************************
    // Read data
    // ****************************************
    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (hit_psc) begin
            rd_nxt[1:0] = psc_r;
        end else if (hit_tb0) begin
            rd_nxt[7:0] = tb_ctl_r[0];
        end else if (hit_tb1) begin
            rd_nxt[7:0] = tb_ctl_r[1];
        end else if (hit_flag) begin
            rd_nxt[NSRC-1:0] = src_flag_r;
            rd_nxt[CONV_BIT] = conv_flag_r;
            rd_nxt[ASYNC_BIT] = async_flag_r;
        end else if (hit_en) begin
            rd_nxt[NSRC-1:0] = src_en_r;
            rd_nxt[CONV_BIT] = conv_en_r;
            rd_nxt[ASYNC_BIT] = async_en_r;
            rd_nxt[MASTER_BIT] = master_r;
        end else if (hit_stat) begin
            rd_nxt[0] = stack_full;
            rd_nxt[1] = |pend;
            rd_nxt[VEC_LSB +: 4] = irq_vector;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup; // One wait-free access after each setup
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? rd_nxt : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psc_r <= PSC_RESET;
            tb_ctl_r[0] <= TB_RESET;
            tb_ctl_r[1] <= TB_RESET;
        end else if (wr) begin
            if (hit_psc) psc_r <= pwdata[1:0];
            if (hit_tb0) tb_ctl_r[0] <= pwdata[7:0] & 8'h87;
            if (hit_tb1) tb_ctl_r[1] <= pwdata[7:0] & 8'h87;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_en_r <= '0;
            conv_en_r <= 1'b0;
            async_en_r <= 1'b0;
        end else if (wr_en) begin
            src_en_r <= pwdata[NSRC-1:0];
            conv_en_r <= pwdata[CONV_BIT];
            async_en_r <= pwdata[ASYNC_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_flag_r <= '0;
            conv_flag_r <= 1'b0;
            async_flag_r <= 1'b0;
            master_r <= 1'b0;
        end else begin
            src_flag_r <= src_flag_nxt;
            conv_flag_r <= conv_flag_nxt;
            async_flag_r <= async_flag_nxt;
            master_r <= master_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_take <= 1'b0;
            irq_vector <= 4'h0;
            wake <= 1'b0;
            flag_prev_r <= '0;
            cmp_prev_r <= 2'h0;
        end else begin
            irq_take <= can_take;
            if (can_take) irq_vector <= win;
            flag_prev_r <= src_flag_r;
            wake <= |(src_flag_r & ~flag_prev_r);
            cmp_prev_r <= cmp_out;
        end
    end

    // Sub clock comes from a pin: two stages before the edge detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_s1_r <= 1'b0;
            sub_s2_r <= 1'b0;
            sub_s3_r <= 1'b0;
            div_r <= 2'h0;
        end else begin
            sub_s1_r <= sub_clk_pin;
            sub_s2_r <= sub_s1_r;
            sub_s3_r <= sub_s2_r;
            div_r <= div_r + 2'h1;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_take;
        can_take ##1 irq_take;
    endsequence

    // Checked in the cycle the vector shows, so irq_take is still high there
    sequence s_after_take;
        !master_r && (irq_vector == $past(win));
    endsequence

    a_cmp_toggle_set: assert property (
        cmp_out[0] != cmp_prev_r[0] |=> src_flag_r[SRC_CMP0])
        else $error("comparator toggle did not set flag");
    a_take_gated: assert property (
        irq_take |-> $past(master_r) && !$past(stack_full)
            && ((($past(src_en_r) >> irq_vector) & NSRC'(1)) != '0))
        else $error("vector taken without enables");
    a_stack_hold: assert property (
        stack_full && (|pend) |=> !irq_take)
        else $error("vector taken with full stack");
    a_take_clears: assert property (
        s_take |-> s_after_take)
        else $error("take did not clear master");
    a_sim_set: assert property (
        sim_set |=> src_flag_r[SRC_SIM])
        else $error("serial module flag not set");
    a_sport_set: assert property (
        sport_set |=> src_flag_r[SRC_SPORT])
        else $error("second port flag not set");
    a_tb_set: assert property (
        tb_ovf[1] |=> src_flag_r[SRC_TB0 + 1])
        else $error("time base flag not set");
    a_group_set: assert property (
        conv_rise |=> src_flag_r[SRC_GRP0 + GRP_CONV])
        else $error("group flag not set by member");
    a_wake_rise: assert property (
        $rose(src_flag_r[SRC_SIM]) |=> wake)
        else $error("flag rise gave no wake");
    a_return_from_irq_master: assert property (
        return_from_irq && !can_take |=> master_r)
        else $error("return did not restore master");
    a_one_take: assert property (
        irq_take |-> ##1 !irq_take ##1 !irq_take)
        else $error("back to back vectors");
    a_take_priority: assert property (
        irq_take |-> (($past(pend) & ((NSRC'(1) << irq_vector) - NSRC'(1))) == '0))
        else $error("vector skipped a higher request");
    a_take_flag_clr: assert property (
        irq_take |-> ((src_flag_r & ~$past(src_set) & (NSRC'(1) << irq_vector)) == '0))
        else $error("taken flag not cleared");
    a_master_gate: assert property (
        !master_r |=> !irq_take)
        else $error("vector taken with master off");
    a_cmp1_set: assert property (
        cmp_out[1] != cmp_prev_r[1] |=> src_flag_r[SRC_CMP0 + 1])
        else $error("second comparator flag not set");
    a_tb0_set: assert property (
        tb_ovf[0] |=> src_flag_r[SRC_TB0])
        else $error("time base 0 flag not set");
    a_conv_set: assert property (
        conv_done |=> conv_flag_r)
        else $error("converter flag not set");
    a_async_set: assert property (
        async_set |=> async_flag_r)
        else $error("async port flag not set");
    a_member_kept: assert property (
        conv_flag_r && !(wr_flag && pwdata[CONV_BIT]) |=> conv_flag_r)
        else $error("member flag lost without software clear");
    a_flag_hold: assert property (
        src_flag_r[SRC_SIM] && !can_take && !wr_flag |=> src_flag_r[SRC_SIM])
        else $error("pending flag dropped");
    a_psc_read: assert property (
        setup && hit_psc && !pwrite |=> prdata[31:2] == '0)
        else $error("unused prescaler bits read nonzero");
    a_wake_any: assert property (
        (|(src_flag_r & ~$past(src_flag_r))) |=> wake)
        else $error("flag rise gave no wake");
endmodule
`default_nettype wire

// >>> tb/core_stack_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_stack_model #(
    parameter int DEPTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq_take,
    input wire logic ret_req,
    output logic stack_full,
    output logic return_from_irq
);
    // ****************************************
    // Return-address stack of the core
    // ****************************************
    logic [3:0] depth_r;
    // One push per vector call, one pop per return; the bench never pops empty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_r <= 4'h0;
            return_from_irq <= 1'b0;
        end else begin
            depth_r <= depth_r + {3'h0, irq_take} - {3'h0, ret_req};
            return_from_irq <= ret_req;
        end
    end
    // Small depth so that a single unreturned call fills it
    assign stack_full = (depth_r == DEPTH[3:0]);
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top import irq_pkg::*;;
    // ****************************************
    // Harness
    // ****************************************
    localparam logic [31:0] MASTER = 32'h1 << MASTER_BIT;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, en;
    logic pready, pslverr, err, irq_take, wake, stack_full, return_from_irq;
    logic ret_req = 1'b0;
    logic sub_clk = 1'b0;
    logic [1:0] cmp_out = 2'h0;
    sim_events_t sim_ev = 3'h0;
    sport_events_t sport_ev = 2'h0;
    logic conv_done = 1'b0;
    async_events_t async_ev = 6'h00;
    logic [NGRP-1:0] grp = 6'h00;
    logic [3:0] irq_vector;
    int failures = 0;
    int compares = 0;
    int c;
    always #10 pclk = ~pclk;
    // Slow sub clock, offset so its edges never meet a pclk edge
    initial begin
        #5;
        forever #250 sub_clk = ~sub_clk;
    end
    periph_irq_timebase DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_out(cmp_out), .sim_ev(sim_ev), .sport_ev(sport_ev),
        .conv_done(conv_done), .async_ev(async_ev), .group_ext_set(grp),
        .sub_clk_pin(sub_clk), .stack_full(stack_full), .return_from_irq(return_from_irq),
        .irq_take(irq_take), .irq_vector(irq_vector), .wake(wake));
    core_stack_model #(.DEPTH(1)) stack_model (.pclk(pclk), .presetn(presetn),
        .irq_take(irq_take), .ret_req(ret_req), .stack_full(stack_full),
        .return_from_irq(return_from_irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            failures++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic ret;
        @(posedge pclk);
        ret_req <= 1'b1;
        @(posedge pclk);
        ret_req <= 1'b0;
    endtask
    task automatic wait_take(input int n, input logic e, input logic [3:0] v);
        int i;
        logic hit;
        hit = 1'b0;
        for (i = 0; i < n; i++) begin
            @(negedge pclk);
            if (irq_take === 1'b1) begin
                hit = 1'b1;
                break;
            end
        end
        chk({31'h0, hit}, {31'h0, e});
        if (e) chk({28'h0, irq_vector}, {28'h0, v});
    endtask
    task automatic wait_wake(input int n, output int cnt);
        for (cnt = 0; cnt < n; cnt++) begin
            @(negedge pclk);
            if (wake === 1'b1) break;
        end
    endtask
    task automatic ev(input logic [2:0] s, input logic [1:0] p, input logic cv,
        input logic [5:0] a, input logic [5:0] g);
        @(posedge pclk);
        sim_ev <= s;
        sport_ev <= p;
        conv_done <= cv;
        async_ev <= a;
        grp <= g;
        @(posedge pclk);
        sim_ev <= 3'h0;
        sport_ev <= 2'h0;
        conv_done <= 1'b0;
        async_ev <= 6'h00;
        grp <= 6'h00;
    endtask
    task automatic tb_time(input logic [7:0] ofs, input logic [31:0] psc,
        input logic [31:0] ctl, input int lo, input int hi);
        do_reset();
        apb(1'b1, OFS_PSC, psc);
        apb(1'b1, ofs, ctl);
        wait_wake(hi + 20, c);
        chk({31'h0, c >= lo && c <= hi}, 32'h1);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        rdchk(OFS_PSC, 32'h0);
        rdchk(OFS_TB0, 32'h0);
        rdchk(OFS_TB1, 32'h0);
        apb(1'b1, OFS_PSC, 32'hFFFFFFFF);
        rdchk(OFS_PSC, 32'h3);
        apb(1'b1, OFS_TB0, 32'hFFFFFF7F);
        rdchk(OFS_TB0, 32'h7);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask
    task automatic t_cmp;
        en = 32'h1;
        apb(1'b1, OFS_EN, en);
        @(posedge pclk);
        cmp_out <= 2'h1;
        wait_wake(10, c);
        chk({31'h0, c < 10}, 32'h1);
        wait_take(10, 1'b0, 4'h0);
        rdchk(OFS_FLAG, 32'h1);
        apb(1'b1, OFS_EN, en | MASTER);
        wait_take(10, 1'b1, 4'h0);
        rdchk(OFS_FLAG, 32'h0);
        rdchk(OFS_EN, en);
        ret();
        rdchk(OFS_EN, en | MASTER);
        @(posedge pclk);
        cmp_out <= 2'h0;
        wait_take(10, 1'b1, 4'h0);
        ret();
    endtask
    task automatic t_stack;
        en = 32'h2 | MASTER;
        apb(1'b1, OFS_EN, en);
        @(posedge pclk);
        cmp_out <= 2'h2;
        wait_take(10, 1'b1, 4'h1);
        apb(1'b1, OFS_EN, en);
        @(posedge pclk);
        cmp_out <= 2'h0;
        wait_take(30, 1'b0, 4'h0);
        rdchk(OFS_FLAG, 32'h2);
        rdchk(OFS_STAT, 32'h13);
        ret();
        wait_take(10, 1'b1, 4'h1);
        ret();
    endtask
    task automatic t_serial;
        apb(1'b1, OFS_EN, 32'h0);
        for (int i = 0; i < 3; i++) begin
            ev(3'h1 << i, 2'h0, 1'b0, 6'h00, 6'h00);
            rdchk(OFS_FLAG, 32'h4);
            apb(1'b1, OFS_FLAG, 32'h4);
        end
        for (int i = 0; i < 2; i++) begin
            ev(3'h0, 2'h1 << i, 1'b0, 6'h00, 6'h00);
            rdchk(OFS_FLAG, 32'h8);
            apb(1'b1, OFS_FLAG, 32'h8);
        end
        ev(3'h4, 2'h2, 1'b0, 6'h00, 6'h00);
        apb(1'b1, OFS_EN, 32'hC | MASTER);
        wait_take(10, 1'b1, 4'h2);
        rdchk(OFS_FLAG, 32'h8);
        ret();
        wait_take(10, 1'b1, 4'h3);
        rdchk(OFS_FLAG, 32'h0);
        ret();
    endtask
    task automatic t_group;
        en = 32'h30C0;
        apb(1'b1, OFS_EN, en);
        ev(3'h0, 2'h0, 1'b1, 6'h00, 6'h00);
        rdchk(OFS_FLAG, 32'h1040);
        apb(1'b1, OFS_EN, en | MASTER);
        wait_take(10, 1'b1, 4'h6);
        rdchk(OFS_FLAG, 32'h1000);
        ret();
        apb(1'b1, OFS_EN, en);
        apb(1'b1, OFS_FLAG, 32'h1000);
        rdchk(OFS_FLAG, 32'h0);
        for (int i = 0; i < 6; i++) begin
            ev(3'h0, 2'h0, 1'b0, 6'h01 << i, 6'h00);
            rdchk(OFS_FLAG, 32'h2080);
            apb(1'b1, OFS_FLAG, 32'h2080);
        end
        ev(3'h0, 2'h0, 1'b0, 6'h00, 6'h04);
        rdchk(OFS_FLAG, 32'h100);
    endtask
    task automatic t_timebase;
        tb_time(OFS_TB0, 32'h0, 32'h80, 250, 270);
        tb_time(OFS_TB0, 32'h0, 32'h87, 32760, 32780);
        tb_time(OFS_TB0, 32'h1, 32'h80, 1015, 1040);
        tb_time(OFS_TB1, 32'h3, 32'h81, 12776, 12806);
        do_reset();
        apb(1'b1, OFS_EN, 32'h10 | MASTER);
        apb(1'b1, OFS_TB0, 32'h80);
        wait_take(300, 1'b1, 4'h4);
        apb(1'b1, OFS_TB0, 32'h07);
        rdchk(OFS_FLAG, 32'h0);
        ret();
        wait_wake(400, c);
        chk({31'h0, c == 400}, 32'h1);
    endtask
    initial begin
        do_reset();
        t_regs();
        t_cmp();
        t_stack();
        t_serial();
        t_group();
        t_timebase();
        final_report();
    end
endmodule
`default_nettype wire
